// ==== verilog/converter_module_pkg.sv ====
// constants and types for the converter module control block
// Summary of operation
// RULE1 - respond only to own wired device address
// RULE2 - track between conversions, hold during conversion
// RULE3 - start by command, timer pulse or external; the code starts only by command or gated external, not by timer pulse
// RULE4 - high-resolution result is 13-bit two's complement
// RULE5 - low-resolution result is 10-bit two's complement
// RULE6 - result latched stable until next result
// RULE7 - data sense true when new word loaded
// RULE8 - timer sense true after timer pulse
// RULE9 - external sense reflects external input level
// RULE10 - timer counts down, pulses at zero
// RULE11 - each cycle reloads from held interval buffer
// RULE12 - continuous mode reloads immediately at cycle end
// RULE13 - single-cycle mode stops until external restart
// RULE14 - ready and interval-complete brought out for interrupts
// RULE15 - block transfer moves words without input instructions
// RULE16 - sensed timer ready cleared after sense
// RULE17 - data ready false at start, true at end
// RULE18 - commands open and close external start gate
// RULE19 - interval write loads, restarts, clears timer ready
// RULE20 - reset clears flags, closes gate, tracks
package converter_module_pkg;
  localparam int unsigned clk_mhz = 100;
  localparam logic [5:0] dev_addr_base = 6'h30;
  localparam logic [5:0] dev_addr_last = 6'h37;
  localparam logic [3:0] fn_block_connect = 4'h0;
  localparam logic [3:0] fn_start = 4'h1;
  localparam logic [3:0] fn_gate_open = 4'h2;
  localparam logic [3:0] fn_gate_close = 4'h3;
  localparam logic [3:0] fn_sense_data = 4'h0;
  localparam logic [3:0] fn_sense_timer = 4'h1;
  localparam logic [3:0] fn_sense_ext = 4'h2;
  localparam int unsigned tick_ns_hi = 1000;
  localparam int unsigned tick_ns_lo = 500;
  localparam logic [7:0] tick_cycles_hi = 8'(tick_ns_hi * clk_mhz / 1000);
  localparam logic [7:0] tick_cycles_lo = 8'(tick_ns_lo * clk_mhz / 1000);
  localparam logic [15:0] interval_reset = 16'h0000;
  localparam int unsigned result_bits_hi = 13;
  localparam int unsigned result_bits_lo = 10;
  typedef enum logic [2:0] {
    conv_idle = 3'b001,
    conv_run = 3'b010,
    conv_done = 3'b100
  } conv_state_e;
endpackage : converter_module_pkg

// ==== verilog/interval_timer.sv ====
// programmable down-counting interval timer
`timescale 1ns/100ps
module interval_timer
  import converter_module_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic low_res,
  input wire logic continuous_mode,
  input wire logic interval_write,
  input wire logic [15:0] interval_data,
  input wire logic ext_timer_start,
  output logic timer_pulse
);
  logic [15:0] interval_buf, next_interval_buf;
  logic [15:0] count, next_count;
  logic [7:0] tick_div, next_tick_div;
  logic running, next_running;
  logic next_timer_pulse;
  logic tick;

  always_comb begin
    tick = (tick_div == 8'h00);
    next_tick_div = tick ? ((low_res ? tick_cycles_lo : tick_cycles_hi) - 8'h01)
                         : tick_div - 8'h01;
    next_interval_buf = interval_buf;
    next_count = count;
    next_running = running;
    next_timer_pulse = 1'b0;
    if (interval_write) begin
      next_interval_buf = interval_data; // RULE11
      next_count = interval_data; // RULE19
      next_running = 1'b1;
      next_tick_div = (low_res ? tick_cycles_lo : tick_cycles_hi) - 8'h01;
    end else if (!running && ext_timer_start) begin
      next_count = interval_buf; // RULE13
      next_running = 1'b1;
    end else if (running && tick) begin
      if (count <= 16'h0001) begin
        next_timer_pulse = 1'b1; // RULE10
        next_count = interval_buf; // RULE12
        next_running = continuous_mode; // RULE13
      end else begin
        next_count = count - 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      interval_buf <= interval_reset;
      count <= interval_reset;
      tick_div <= 8'h00;
      running <= 1'b0;
      timer_pulse <= 1'b0;
    end else begin
      interval_buf <= next_interval_buf;
      count <= next_count;
      tick_div <= next_tick_div;
      running <= next_running;
      timer_pulse <= next_timer_pulse;
    end
  end
endmodule : interval_timer

// ==== verilog/converter_module.sv ====
// converter module control: decode, start, hold, result buffer, sense
`timescale 1ns/100ps
module converter_module
  import converter_module_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr_strap,
  input wire logic low_res,
  input wire logic continuous_mode,
  input wire logic [5:0] bus_dev_addr,
  input wire logic [3:0] bus_function,
  input wire logic external_control_command,
  input wire logic sense_instruction,
  input wire logic sense_done,
  input wire logic data_out_strobe,
  input wire logic data_in_strobe,
  input wire logic [15:0] bus_data_out,
  input wire logic ext_start,
  input wire logic ext_timer_start,
  input wire logic ext_sense_in,
  input wire logic adc_busy,
  input wire logic adc_result_valid,
  input wire logic [12:0] adc_result,
  input wire logic block_transfer_ack,
  output logic hold,
  output logic adc_start,
  output logic sense_response,
  output logic [15:0] bus_data_in,
  output logic data_ready,
  output logic timer_ready,
  output logic timer_pulse,
  output logic block_transfer_request
);
  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic selected;
  assign selected = (bus_dev_addr == (dev_addr_base | {3'b000, addr_strap})); // RULE1

  logic cmd_start, cmd_gate_open, cmd_gate_close, cmd_block;
  logic sense_data, sense_timer, sense_ext;
  logic interval_write, data_read;
  assign cmd_start = selected && external_control_command && bus_function == fn_start;
  assign cmd_gate_open = selected && external_control_command && bus_function == fn_gate_open;
  assign cmd_gate_close = selected && external_control_command
                          && bus_function == fn_gate_close;
  assign cmd_block = selected && external_control_command
                     && bus_function == fn_block_connect;
  assign sense_data = selected && sense_instruction && bus_function == fn_sense_data;
  assign sense_timer = selected && sense_instruction && bus_function == fn_sense_timer;
  assign sense_ext = selected && sense_instruction && bus_function == fn_sense_ext;
  assign interval_write = selected && data_out_strobe; // RULE19
  assign data_read = selected && data_in_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // timer
  interval_timer u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .low_res(low_res),
    .continuous_mode(continuous_mode),
    .interval_write(interval_write),
    .interval_data(bus_data_out),
    .ext_timer_start(ext_timer_start),
    .timer_pulse(timer_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // conversion control
  conv_state_e state, next_state;
  logic gate_open, next_gate_open;
  logic block_mode, next_block_mode;
  logic next_hold, next_adc_start;
  logic next_data_ready, next_timer_ready;
  logic [15:0] next_bus_data_in;
  logic timer_sensed, next_timer_sensed;
  logic start_req;
  logic [15:0] result_word;

  // sign extend the converter word to the bus width per variant
  always_comb begin
    if (low_res) begin
      result_word = {{6{adc_result[result_bits_lo - 1]}},
                     adc_result[result_bits_lo - 1:0]}; // RULE5
    end else begin
      result_word = {{3{adc_result[result_bits_hi - 1]}},
                     adc_result[result_bits_hi - 1:0]}; // RULE4
    end
  end

  // program start ignores the gate; external start only while gate open
  assign start_req = cmd_start || (gate_open && ext_start); // RULE3 RULE18

  always_comb begin
    next_state = state;
    next_gate_open = gate_open;
    next_block_mode = block_mode;
    next_hold = hold;
    next_adc_start = 1'b0;
    next_data_ready = data_ready;
    next_timer_ready = timer_ready;
    next_timer_sensed = timer_sensed;
    next_bus_data_in = bus_data_in;
    if (cmd_gate_open) begin
      next_gate_open = 1'b1; // RULE18
    end else if (cmd_gate_close) begin
      next_gate_open = 1'b0; // RULE18
    end
    if (cmd_block) begin
      next_block_mode = 1'b1; // RULE15
    end
    if (data_read || (block_mode && block_transfer_ack)) begin
      next_data_ready = 1'b0; // RULE17
    end
    case (state)
      conv_idle: begin
        if (start_req) begin
          next_hold = 1'b1; // RULE2
          next_adc_start = 1'b1;
          next_data_ready = 1'b0; // RULE17
          next_state = conv_run;
        end
      end
      conv_run: begin
        if (adc_result_valid) begin
          next_bus_data_in = result_word; // RULE6
          next_data_ready = 1'b1; // RULE7 RULE17
          next_state = conv_done;
        end
      end
      conv_done: begin
        // release the hold only once the converter drops busy
        if (!adc_busy) begin
          next_hold = 1'b0; // RULE2
          next_state = conv_idle;
        end
      end
      default: begin
        next_hold = 1'b0;
        next_state = conv_idle;
      end
    endcase
    // timer ready: pulse sets (wins over clear), sense then clears
    if (sense_timer && timer_ready) begin
      next_timer_sensed = 1'b1;
    end
    if (interval_write) begin
      next_timer_ready = 1'b0; // RULE19
      next_timer_sensed = 1'b0;
    // a one-cycle sense may complete in the cycle that finds the flag true
    end else if ((timer_sensed || (sense_timer && timer_ready)) && sense_done) begin
      next_timer_ready = 1'b0; // RULE16
      next_timer_sensed = 1'b0;
    end
    if (timer_pulse) begin
      next_timer_ready = 1'b1; // RULE8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= conv_idle;
      gate_open <= 1'b0; // RULE20
      block_mode <= 1'b0;
      hold <= 1'b0; // RULE20
      adc_start <= 1'b0;
      data_ready <= 1'b0; // RULE20
      timer_ready <= 1'b0; // RULE20
      timer_sensed <= 1'b0;
      bus_data_in <= 16'h0000;
    end else begin
      state <= next_state;
      gate_open <= next_gate_open;
      block_mode <= next_block_mode;
      hold <= next_hold;
      adc_start <= next_adc_start;
      data_ready <= next_data_ready;
      timer_ready <= next_timer_ready;
      timer_sensed <= next_timer_sensed;
      bus_data_in <= next_bus_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense answer and outputs for interrupts / block transfer
  always_comb begin
    sense_response = 1'b0;
    if (sense_data) begin
      sense_response = data_ready; // RULE7
    end else if (sense_timer) begin
      sense_response = timer_ready; // RULE8
    end else if (sense_ext) begin
      sense_response = ext_sense_in; // RULE9
    end
  end

  // data_ready and timer_ready are outputs for the interrupt unit RULE14
  assign block_transfer_request = block_mode && data_ready; // RULE15
endmodule : converter_module

// ==== dv/converter_model.sv ====
// behavioural converter: busy after a start, then one result pulse
`timescale 1ns/100ps
module converter_model (
  input wire logic ref_clk,
  input wire logic adc_start,
  input wire logic [12:0] sample,
  input wire logic [7:0] latency,
  output logic adc_busy = 1'h0,
  output logic adc_result_valid = 1'h0,
  output logic [12:0] adc_result = 13'h0000
);
  int cnt = 0;
  always @(posedge ref_clk) begin
    adc_result_valid <= 1'h0;
    // word changes every cycle so a late latch cannot pass by luck
    adc_result <= ~adc_result;
    if (adc_start) begin
      adc_busy <= 1'h1;
      cnt <= int'(latency);
    end else if (cnt == 1) begin
      adc_result_valid <= 1'h1;
      adc_result <= sample;
    end else if (cnt == 0) begin
      adc_busy <= 1'h0;
    end
    if (!adc_start && cnt > 0) cnt <= cnt - 1;
  end
endmodule : converter_model

// ==== dv/converter_module_sva.sv ====
// port assertions for the converter module control block
`timescale 1ns/100ps
module converter_module_sva
  import converter_module_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] addr_strap,
  input wire logic [5:0] bus_dev_addr,
  input wire logic [3:0] bus_function,
  input wire logic sense_instruction,
  input wire logic data_out_strobe,
  input wire logic ext_sense_in,
  input wire logic adc_result_valid,
  input wire logic hold,
  input wire logic adc_start,
  input wire logic sense_response,
  input wire logic [15:0] bus_data_in,
  input wire logic data_ready,
  input wire logic timer_ready,
  input wire logic timer_pulse
);
  logic sel;
  assign sel = bus_dev_addr == (dev_addr_base | {3'h0, addr_strap});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_start_holds: assert property (adc_start |-> hold && !data_ready)
    else $error("hold or ready wrong at start");
  a_start_single: assert property (adc_start |=> !adc_start)
    else $error("start pulse too long");
  a_result_ready: assert property (adc_result_valid |=> data_ready)
    else $error("ready missing after result");
  a_result_stable: assert property (!adc_result_valid |=> $stable(bus_data_in))
    else $error("result word changed");
  a_pulse_ready: assert property (timer_pulse |=> timer_ready)
    else $error("timer ready missing");
  a_ext_level: assert property (sense_instruction && sel && bus_function == fn_sense_ext
    |-> sense_response == ext_sense_in)
    else $error("external sense wrong");
  a_foreign_addr: assert property (sense_instruction && !sel |-> !sense_response)
    else $error("answered foreign address");
  a_write_clears: assert property (data_out_strobe && sel && !timer_pulse |=> !timer_ready)
    else $error("interval write kept ready");
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> !hold && !data_ready)
    else $error("not idle after reset");
endmodule : converter_module_sva
bind converter_module converter_module_sva chk_u (.ref_clk, .sys_rst, .addr_strap,
  .bus_dev_addr, .bus_function, .sense_instruction, .data_out_strobe, .ext_sense_in,
  .adc_result_valid, .hold, .adc_start, .sense_response, .bus_data_in, .data_ready,
  .timer_ready, .timer_pulse);

// ==== dv/converter_module_tb.sv ====
// self-checking bench for the converter module control block
`timescale 1ns/100ps
module converter_module_tb import converter_module_pkg::*;;
  logic ref_clk = 1'h0, sys_rst = 1'h1, low_res = 1'h0, continuous_mode = 1'h1;
  logic external_control_command = 1'h0, sense_instruction = 1'h0, sense_done = 1'h0;
  logic data_out_strobe = 1'h0, data_in_strobe = 1'h0, ext_start = 1'h0, ext_sense_in = 1'h0;
  logic ext_timer_start = 1'h0, block_transfer_ack = 1'h0, hold, adc_start, sense_response;
  logic data_ready, timer_ready, timer_pulse, block_transfer_request, adc_busy, adc_result_valid;
  logic [2:0] addr_strap = 3'h0;
  logic [5:0] bus_dev_addr = 6'h00, sel;
  logic [3:0] bus_function = 4'h0;
  logic [15:0] bus_data_out = 16'h0000, bus_data_in;
  logic [12:0] adc_result, sample = 13'h0000;
  logic [7:0] latency = 8'h02;
  logic [31:0] rng = 32'h9F6A;
  logic [15:0] exp_q[$];
  int miscompares = 0, total_checks = 0, cyc = 0, n;
  converter_module dut_u (.ref_clk, .sys_rst, .addr_strap, .low_res, .continuous_mode,
    .bus_dev_addr, .bus_function, .external_control_command, .sense_instruction, .sense_done,
    .data_out_strobe, .data_in_strobe, .bus_data_out, .ext_start, .ext_timer_start,
    .ext_sense_in, .adc_busy, .adc_result_valid, .adc_result, .block_transfer_ack, .hold,
    .adc_start, .sense_response, .bus_data_in, .data_ready, .timer_ready, .timer_pulse,
    .block_transfer_request);
  converter_model adc_u (.ref_clk, .adc_start, .sample, .latency, .adc_busy,
    .adc_result_valid, .adc_result);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] sx(input logic [12:0] v, input logic lr);
    return lr ? {{6{v[9]}}, v[9:0]} : {{3{v[12]}}, v};
  endfunction : sx
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, seen, want);
    end
  endtask : chk
  task automatic cmd(input logic [5:0] a, input logic [3:0] f);
    bus_dev_addr = a;
    bus_function = f;
    external_control_command = 1'h1;
    step();
    external_control_command = 1'h0;
  endtask : cmd
  task automatic sense(input logic [3:0] f, input logic want);
    bus_dev_addr = sel;
    bus_function = f;
    sense_instruction = 1'h1;
    sense_done = 1'h1;
    #1 chk(sense_response, want);
    step();
    sense_instruction = 1'h0;
    sense_done = 1'h0;
  endtask : sense
  task automatic conv;
    while (data_ready !== 1'h1) step();
    chk(bus_data_in, exp_q.pop_front());
    repeat (3) step();
    chk(hold, 1'h0);
    sense(fn_sense_data, 1'h1);
    data_in_strobe = 1'h1;
    step();
    data_in_strobe = 1'h0;
    chk(data_ready, 1'h0);
  endtask : conv
  task automatic results;
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  initial begin
    rng = xs(rng);
    addr_strap = rng[2:0];
    sel = dev_addr_base | {3'h0, addr_strap};
    repeat (5) step();
    sys_rst = 1'h0;
    chk({data_ready, timer_ready, hold}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      sample = rng[12:0];
      low_res = i[0];
      latency = i < 3 ? 8'h02 : 8'h28;
      exp_q.push_back(sx(sample, low_res));
      cmd(sel, fn_start);
      chk(hold, 1'h1);
      conv();
    end
    cmd(sel ^ 6'h01, fn_start);
    chk(hold, 1'h0);
    ext_start = 1'h1;
    step();
    ext_start = 1'h0;
    chk(hold, 1'h0);
    cmd(sel, fn_gate_open);
    exp_q.push_back(sx(sample, low_res));
    ext_start = 1'h1;
    step();
    ext_start = 1'h0;
    chk(hold, 1'h1);
    conv();
    cmd(sel, fn_gate_close);
    for (int v = 0; v < 2; v++) begin
      ext_sense_in = v[0];
      sense(fn_sense_ext, v[0]);
    end
    low_res = 1'h0;
    bus_data_out = 16'h0002;
    data_out_strobe = 1'h1;
    step();
    data_out_strobe = 1'h0;
    chk(timer_ready, 1'h0);
    while (timer_pulse !== 1'h1) step();
    n = 0;
    step();
    while (timer_pulse !== 1'h1) begin
      step();
      n++;
    end
    chk(16'(n), 16'h00C7);
    step();
    chk(timer_ready, 1'h1);
    sense(fn_sense_timer, 1'h1);
    chk(timer_ready, 1'h0);
    continuous_mode = 1'h0;
    while (timer_pulse !== 1'h1) step();
    n = 0;
    repeat (300) begin
      step();
      n += timer_pulse;
    end
    chk(16'(n), 16'h0000);
    ext_timer_start = 1'h1;
    step();
    ext_timer_start = 1'h0;
    n = 0;
    while (timer_pulse !== 1'h1) begin
      step();
      n++;
    end
    chk(16'((n + 5) / 10), 16'h0014);
    cmd(sel, fn_block_connect);
    cmd(sel, fn_start);
    while (data_ready !== 1'h1) step();
    chk(block_transfer_request, 1'h1);
    block_transfer_ack = 1'h1;
    step();
    block_transfer_ack = 1'h0;
    chk({data_ready, block_transfer_request}, 16'h0000);
    results();
  end
endmodule : converter_module_tb
